// ===== gcts_cmd_decode.sv
/*
 Register address formation and global command decoding.
 Assumes one access per acc_valid_i pulse from the framer.
*/
`timescale 1ns/1ps
module gcts_cmd_decode
    import gcts_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic i2c_mode_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [7:0] acc_cmd_i,
    input wire logic [6:0] acc_i2c_addr_i,
    input wire logic [1:0] acc_i2c_chan_i,
    input wire logic [7:0] acc_wdata_i,
    gcts_cmd_if.dec bus
);
    typedef struct packed {
        logic ext;
        logic trig;
        logic [3:0] num;
    } gcts_dec_state_t;

    gcts_dec_state_t q, d;
    logic write_dir;
    logic glob_hit;
    logic glob_wr;

    assign write_dir = i2c_mode_i ? acc_write_i : acc_cmd_i[SPI_WR_BIT]; // R21
    assign glob_hit = i2c_mode_i ? (acc_i2c_addr_i == ADDR_GLOBAL_CMD[6:0])
                                 : (acc_cmd_i[4:0] == ADDR_GLOBAL_CMD[4:0]);
    assign glob_wr = acc_valid_i & write_dir & glob_hit;
    assign bus.wr = acc_valid_i & write_dir;
    assign bus.rd = acc_valid_i & ~write_dir;
    assign bus.glob = glob_wr;
    assign bus.wdata = acc_wdata_i;
    assign bus.chan = i2c_mode_i ? acc_i2c_chan_i : acc_cmd_i[SPI_CH_MSB:SPI_CH_LSB]; // R5
    assign bus.addr = i2c_mode_i ? {1'b0, acc_i2c_addr_i} // R7
                    : q.ext ? {EXT_PREFIX, acc_cmd_i[3:0]} // R3 R4
                    : {STD_PREFIX, acc_cmd_i[4:0]}; // R6
    assign bus.ext = q.ext;
    assign bus.trig_p = q.trig; // R1
    assign bus.trig_num = q.num;

    always_comb
    begin
        d = q;
        d.trig = 1'b0; // R22
        if (glob_wr)
        begin
            if (acc_wdata_i == CMD_EXT_ON)
            begin
                d.ext = 1'b1; // R2
            end
            else if (acc_wdata_i == CMD_EXT_OFF)
            begin
                d.ext = 1'b0; // R6
            end
            else if (acc_wdata_i[7:4] == CMD_TRIG_HI)
            begin
                d.trig = 1'b1; // R8
                d.num = acc_wdata_i[3:0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0; // R23
        end
        else
        begin
            q <= d;
        end
    end

    ext_enter_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        glob_wr && acc_wdata_i == CMD_EXT_ON |=> q.ext && !q.trig)
        else $error("extended mode not entered");
    ext_addr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        q.ext && !i2c_mode_i |-> bus.addr == {4'h2, acc_cmd_i[3:0]})
        else $error("extended address wrong");
    trig_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        glob_wr && acc_wdata_i[7:4] == 4'hE |=> q.trig && q.num == $past(acc_wdata_i[3:0]))
        else $error("trigger not decoded");
    other_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
        glob_wr && acc_wdata_i[7:4] != 4'hE && acc_wdata_i != 8'hCE && acc_wdata_i != 8'hCD
        |=> !q.trig && $stable(q.ext))
        else $error("ignored code had effect");
endmodule // gcts_cmd_decode

// ===== gcts_cmd_if.sv
/*
 Decoded register access and global command broadcast.
 Assumes the decoder drives it and the top only reads it.
*/
`timescale 1ns/1ps
interface gcts_cmd_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [1:0] chan;
    logic wr;
    logic rd;
    logic glob;
    logic ext;
    logic trig_p;
    logic [3:0] trig_num;

    modport dec (output addr, wdata, chan, wr, rd, glob, ext, trig_p, trig_num);
    modport top (input addr, wdata, chan, wr, rd, glob, ext, trig_p, trig_num);
endinterface

// ===== gcts_host_model.sv
/*
 Host model: hands register byte accesses to the block as the SPI/I2C
 framer would. Assumes the bench calls its tasks and owns the clock.
*/
`timescale 1ns/1ps
module gcts_host_model
(
    input wire logic clk_i,
    output logic i2c_mode_o,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [7:0] acc_cmd_o,
    output logic [6:0] acc_i2c_addr_o,
    output logic [1:0] acc_i2c_chan_o,
    output logic [7:0] acc_wdata_o
);
    // ------------------------------------------------
    // Access tasks
    // ------------------------------------------------
    initial
    begin
        i2c_mode_o = 1'b0;
        acc_valid_o = 1'b0;
        acc_write_o = 1'b0;
        acc_cmd_o = 8'h00;
        acc_i2c_addr_o = 7'h00;
        acc_i2c_chan_o = 2'h0;
        acc_wdata_o = 8'h00;
    end

    // Released lines show the inverse of their last value
    task automatic drive(input logic wr, input logic [7:0] cmd, input logic [6:0] adr, input logic [1:0] ch,
                         input logic [7:0] d);
        @(posedge clk_i);
        #1;
        acc_valid_o = 1'b1;
        acc_write_o = wr;
        acc_cmd_o = cmd;
        acc_i2c_addr_o = adr;
        acc_i2c_chan_o = ch;
        acc_wdata_o = d;
        @(posedge clk_i);
        #1;
        acc_valid_o = 1'b0;
        acc_write_o = ~wr;
        acc_cmd_o = ~cmd;
        acc_i2c_addr_o = ~adr;
        acc_i2c_chan_o = ~ch;
        acc_wdata_o = ~d;
    endtask

    task automatic spi(input logic wr, input logic [1:0] ch, input logic [4:0] a, input logic [7:0] d);
        drive(wr, {wr, ch, a}, 7'h7F, ~ch, d);
    endtask

    task automatic i2c(input logic wr, input logic [1:0] ch, input logic [6:0] a, input logic [7:0] d);
        drive(wr, 8'h1F, a, ch, d);
    endtask

    task automatic ext(input logic on);
        spi(1'b1, 2'h0, 5'h1F, on ? 8'hCE : 8'hCD);
    endtask

    task automatic set_mode(input logic i2c);
        @(posedge clk_i);
        #1;
        i2c_mode_o = i2c;
    endtask
endmodule // gcts_host_model

// ===== gcts_pin_sync.sv
/*
 Three-stage synchroniser for a pin level.
 Assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module gcts_pin_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic lvl_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } gcts_sync_state_t;

    gcts_sync_state_t q, d;

    always_comb
    begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Level taken only when later stages agree
        if (q.s2 == q.s3)
        begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign lvl_o = q.lvl;
endmodule // gcts_pin_sync

// ===== gcts_pkg.sv
/*
 Constants, state encodings and field layout of the global command
 and transmitter synchronisation block.
 Assumes one 250 MHz clock and an SPI/I2C framer on the same clock.
// How it works
//R1: Global writes reach all four channels together
//R2: Command 0xCE enables SPI extended addressing
//R3: Extended SPI address is 0010 plus nibble
//R4: Address bit four ignored in extended mode
//R5: Channel select bits keep their meaning
//R6: Command 0xCD restores standard five-bit addressing
//R7: I2C uses its seven-bit address directly
//R8: Codes 0xE0 to 0xEF are sixteen triggers
//R9: Extended registers sit at 0x20 to 0x25
//R10: Same trigger number starts all armed channels
//R11: Start is start-bit falling edge on line
//R12: Clock route bit enables GPIO 0/4/8/12
//R13: Auto disable holds transmitter after queue drains
//R14: Delayed start waits programmed bit intervals
//R15: Armed channel starts on trigger with data
//R16: Arming forces transmitter off until trigger
//R17: Unarmed channel ignores every trigger command
//R18: Trigger select field picks the trigger number
//R19: Delay counts bit intervals, low byte first
//R20: Second delay register holds the high byte
//R21: Host command byte is W/R, channel, address
//R22: Other global codes change nothing
//R23: Reset gives standard addressing; delay ticks baud
*/
package gcts_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_GLOBAL_CMD = 8'h1F;
    localparam logic [7:0] ADDR_TX_SYNC = 8'h20;
    localparam logic [7:0] ADDR_DLY_LO = 8'h21;
    localparam logic [7:0] ADDR_DLY_HI = 8'h22;
    localparam logic [7:0] ADDR_TMR_LO = 8'h23;
    localparam logic [7:0] ADDR_TMR_HI = 8'h24;
    localparam logic [7:0] ADDR_REV = 8'h25;

    localparam logic [7:0] TX_SYNC_RST = 8'h00;
    localparam logic [7:0] DLY_LO_RST = 8'h00;
    localparam logic [7:0] DLY_HI_RST = 8'h00;
    localparam logic [7:0] TMR_RST = 8'h00;

    // ----------------------------------------------------------------
    // Global commands and address formation
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_EXT_ON = 8'hCE;
    localparam logic [7:0] CMD_EXT_OFF = 8'hCD;
    localparam logic [3:0] CMD_TRIG_HI = 4'hE;
    localparam logic [3:0] EXT_PREFIX = 4'h2;
    localparam logic [2:0] STD_PREFIX = 3'h0;
    localparam int SPI_WR_BIT = 7;
    localparam int SPI_CH_MSB = 6;
    localparam int SPI_CH_LSB = 5;

    // ----------------------------------------------------------------
    // Sync configuration fields
    // ----------------------------------------------------------------
    localparam int CLK_GPIO_BIT = 7;
    localparam int AUTO_DIS_BIT = 6;
    localparam int DELAYED_BIT = 5;
    localparam int ARM_BIT = 4;
    localparam int TRIG_SEL_MSB = 3;
    localparam int GPIO_STRIDE = 4;
    localparam int CH_COUNT = 4;

    typedef enum logic [1:0] {
        CH_WAIT = 2'h0,
        CH_DELAY = 2'h1,
        CH_RUN = 2'h3
    } gcts_chan_state_t;

endpackage

// ===== gcts_top.sv
/*
 Global command interpreter and transmitter synchronisation for
 four channels, with the extended register page of each channel.
 Assumes the framer gives one acc_valid_i pulse per register byte,
 and each transmitter reports baud ticks, queue state and its line.
*/
`timescale 1ns/1ps
module gcts_top
    import gcts_pkg::*;
#(
    parameter logic [7:0] REV_ID = 8'h5A // Arbitrary value
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic i2c_mode_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [7:0] acc_cmd_i,
    input wire logic [6:0] acc_i2c_addr_i,
    input wire logic [1:0] acc_i2c_chan_i,
    input wire logic [7:0] acc_wdata_i,
    output logic [7:0] acc_rdata_o,
    output logic acc_rvalid_o,
    input wire logic [3:0] baud_tick_i,
    input wire logic [3:0] txq_has_data_i,
    input wire logic [3:0] tx_done_i,
    input wire logic [3:0] tx_line_i,
    input wire logic [3:0] mode_one_register_tx_off_i,
    output logic [3:0] transmitter_off_o,
    output logic [3:0] tx_start_o,
    output logic ext_mode_o,
    output logic [15:0] sysclk_gpio_en_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0][7:0] cfg;
        logic [3:0][7:0] dlo;
        logic [3:0][7:0] dhi;
        logic [3:0][7:0] tlo;
        logic [3:0][7:0] thi;
        gcts_chan_state_t [3:0] st;
        logic [3:0][15:0] cnt;
        logic [3:0] line;
        logic [3:0] start;
        logic [15:0] gpio;
        logic [7:0] rdata;
        logic rvalid;
    } gcts_top_state_t;

    localparam gcts_top_state_t TOP_RST = '{
        cfg: {4{TX_SYNC_RST}},
        dlo: {4{DLY_LO_RST}},
        dhi: {4{DLY_HI_RST}},
        tlo: {4{TMR_RST}},
        thi: {4{TMR_RST}},
        st: '{4{CH_WAIT}},
        line: 4'hF,
        default: '0
    };

    gcts_top_state_t q, d;
    logic i2c_lvl;
    logic [3:0] hold;
    logic [3:0] trig_hit;

    gcts_cmd_if bus ();

    // ------------------------------------------------------------
    // Mode pin and command decoding
    // ------------------------------------------------------------
    gcts_pin_sync u_mode_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(i2c_mode_i),
        .lvl_o(i2c_lvl)
    );

    gcts_cmd_decode u_decode (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .i2c_mode_i(i2c_lvl),
        .acc_valid_i(acc_valid_i),
        .acc_write_i(acc_write_i),
        .acc_cmd_i(acc_cmd_i),
        .acc_i2c_addr_i(acc_i2c_addr_i),
        .acc_i2c_chan_i(acc_i2c_chan_i),
        .acc_wdata_i(acc_wdata_i),
        .bus(bus.dec)
    );

    // ------------------------------------------------------------
    // Channel hold and trigger match
    // ------------------------------------------------------------
    always_comb
    begin
        for (int ch = 0; ch < CH_COUNT; ch++)
        begin
            hold[ch] = q.cfg[ch][ARM_BIT] && (q.st[ch] != CH_RUN); // R16
            trig_hit[ch] = bus.trig_p
                && (bus.trig_num == q.cfg[ch][TRIG_SEL_MSB:0]); // R10 R18
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.rvalid = 1'b0;

        // Channel page writes; the global address is never stored
        if (bus.wr && !bus.glob)
        begin
            case (bus.addr)
                ADDR_TX_SYNC: d.cfg[bus.chan] = bus.wdata; // R9
                ADDR_DLY_LO: d.dlo[bus.chan] = bus.wdata; // R19
                ADDR_DLY_HI: d.dhi[bus.chan] = bus.wdata; // R20
                ADDR_TMR_LO: d.tlo[bus.chan] = bus.wdata;
                ADDR_TMR_HI: d.thi[bus.chan] = bus.wdata;
                default: d.rvalid = 1'b0;
            endcase
        end

        // Reads answer one cycle later; unmapped reads give zero
        if (bus.rd)
        begin
            d.rvalid = 1'b1;
            case (bus.addr)
                ADDR_TX_SYNC: d.rdata = q.cfg[bus.chan]; // R9
                ADDR_DLY_LO: d.rdata = q.dlo[bus.chan];
                ADDR_DLY_HI: d.rdata = q.dhi[bus.chan];
                ADDR_TMR_LO: d.rdata = q.tlo[bus.chan];
                ADDR_TMR_HI: d.rdata = q.thi[bus.chan];
                ADDR_REV: d.rdata = REV_ID;
                default: d.rdata = 8'h00;
            endcase
        end

        for (int ch = 0; ch < CH_COUNT; ch++)
        begin
            d.line[ch] = tx_line_i[ch];
            // Start of transmission is the start bit's falling edge
            d.start[ch] = q.line[ch] && !tx_line_i[ch] && !hold[ch]; // R11
            d.gpio[ch * GPIO_STRIDE] = q.cfg[ch][CLK_GPIO_BIT]; // R12

            if (!q.cfg[ch][ARM_BIT])
            begin
                d.st[ch] = CH_WAIT; // R17
            end
            else
            begin
                case (q.st[ch])
                    CH_WAIT:
                    begin
                        // A trigger finding an empty queue is dropped
                        if (trig_hit[ch] && txq_has_data_i[ch]) // R15
                        begin
                            if (q.cfg[ch][DELAYED_BIT])
                            begin
                                d.st[ch] = CH_DELAY; // R14
                                d.cnt[ch] = {q.dhi[ch], q.dlo[ch]}; // R19 R20
                            end
                            else
                            begin
                                d.st[ch] = CH_RUN;
                            end
                        end
                    end
                    CH_DELAY:
                    begin
                        if (q.cnt[ch] == 16'h0000)
                        begin
                            d.st[ch] = CH_RUN; // R14
                        end
                        else if (baud_tick_i[ch])
                        begin
                            d.cnt[ch] = q.cnt[ch] - 16'h0001; // R23
                        end
                    end
                    CH_RUN:
                    begin
                        if (q.cfg[ch][AUTO_DIS_BIT] && tx_done_i[ch])
                        begin
                            d.st[ch] = CH_WAIT; // R13
                        end
                    end
                    default:
                    begin
                        d.st[ch] = CH_WAIT;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= TOP_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign transmitter_off_o = mode_one_register_tx_off_i | hold; // R16
    assign tx_start_o = q.start;
    assign acc_rdata_o = q.rdata;
    assign acc_rvalid_o = q.rvalid;
    assign ext_mode_o = bus.ext;
    assign sysclk_gpio_en_o = q.gpio;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    read_answer_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        bus.rd && bus.addr == 8'h20 |=> acc_rvalid_o && acc_rdata_o == $past(q.cfg[bus.chan]))
        else $error("sync config read wrong");

    for (genvar g = 0; g < CH_COUNT; g++)
    begin : g_chk
        hold_armed_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
            q.cfg[g][ARM_BIT] && q.st[g] != CH_RUN |-> transmitter_off_o[g])
            else $error("armed channel not held");
        unarmed_trig_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
            bus.trig_p && !q.cfg[g][ARM_BIT] |=> q.st[g] == CH_WAIT)
            else $error("unarmed channel left wait");
        trig_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
            q.st[g] == CH_WAIT && q.cfg[g][ARM_BIT] && !q.cfg[g][DELAYED_BIT]
            && bus.trig_p && bus.trig_num == q.cfg[g][3:0] && txq_has_data_i[g]
            |=> q.st[g] == CH_RUN && transmitter_off_o[g] == mode_one_register_tx_off_i[g])
            else $error("trigger did not release");
        trig_delay_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
            q.st[g] == CH_WAIT && q.cfg[g][ARM_BIT] && q.cfg[g][DELAYED_BIT]
            && bus.trig_p && bus.trig_num == q.cfg[g][3:0] && txq_has_data_i[g]
            |=> q.st[g] == CH_DELAY && q.cnt[g] == {$past(q.dhi[g]), $past(q.dlo[g])})
            else $error("delay not loaded");
        delay_tick_a: assert property (@(posedge clk_i) disable iff (rst_i) // R23
            q.st[g] == CH_DELAY && q.cfg[g][ARM_BIT] && q.cnt[g] != 16'h0000
            && baud_tick_i[g] |=> q.cnt[g] == $past(q.cnt[g]) - 16'h0001)
            else $error("delay not counted");
        auto_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
            q.st[g] == CH_RUN && q.cfg[g][ARM_BIT] && q.cfg[g][AUTO_DIS_BIT]
            && tx_done_i[g] |=> q.st[g] == CH_WAIT && transmitter_off_o[g])
            else $error("auto disable missed");
        start_edge_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
            q.line[g] && !tx_line_i[g] && !hold[g] |=> tx_start_o[g] ##1 !tx_start_o[g])
            else $error("start edge not reported");
        gpio_route_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
            q.cfg[g][CLK_GPIO_BIT] |=> sysclk_gpio_en_o[g * GPIO_STRIDE])
            else $error("clock route not enabled");
    end

endmodule // gcts_top

// ===== gcts_top_test.sv
/*
 Self-checking bench of the global command and transmitter sync block.
 Assumes gcts_pkg, the interface and the host model are compiled first.
*/
`timescale 1ns/1ps
module gcts_top_test;
    import gcts_pkg::*;
    localparam logic [7:0] REV = 8'hA7; // Arbitrary value
    logic clk_i, rst_i, i2c_mode, acc_valid, acc_write, acc_rvalid_o, ext_mode_o;
    logic [7:0] acc_cmd, acc_wdata, acc_rdata_o, seed, er;
    logic [6:0] acc_i2c_addr;
    logic [1:0] acc_i2c_chan;
    logic [3:0] baud_tick_i, txq_has_data_i, tx_done_i, tx_line_i, mode_one_register_tx_off_i;
    logic [3:0] transmitter_off_o, tx_start_o, es, n4;
    logic [15:0] sysclk_gpio_en_o;
    logic [7:0] vals [4][5];
    logic [7:0] codes [8] = '{8'h00, 8'hCC, 8'hCF, 8'hD0, 8'hDF, 8'hF0, 8'hFF, 8'h6E};
    logic [7:0] rq [$];
    logic [3:0] sq [$];
    int error_cnt = 0;
    int checks = 0;

    gcts_host_model host (.clk_i(clk_i), .i2c_mode_o(i2c_mode), .acc_valid_o(acc_valid), .acc_write_o(acc_write),
        .acc_cmd_o(acc_cmd), .acc_i2c_addr_o(acc_i2c_addr), .acc_i2c_chan_o(acc_i2c_chan), .acc_wdata_o(acc_wdata));
    gcts_top #(.REV_ID(REV)) DUT (.clk_i(clk_i), .rst_i(rst_i), .i2c_mode_i(i2c_mode), .acc_valid_i(acc_valid),
        .acc_write_i(acc_write), .acc_cmd_i(acc_cmd), .acc_i2c_addr_i(acc_i2c_addr), .acc_i2c_chan_i(acc_i2c_chan),
        .acc_wdata_i(acc_wdata), .acc_rdata_o(acc_rdata_o), .acc_rvalid_o(acc_rvalid_o), .baud_tick_i(baud_tick_i),
        .txq_has_data_i(txq_has_data_i), .tx_done_i(tx_done_i), .tx_line_i(tx_line_i),
        .mode_one_register_tx_off_i(mode_one_register_tx_off_i), .transmitter_off_o(transmitter_off_o), .tx_start_o(tx_start_o),
        .ext_mode_o(ext_mode_o), .sysclk_gpio_en_o(sysclk_gpio_en_o));

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (rq.size() != 0 || sq.size() != 0)
            error_cnt++;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [1:0] ch, input logic [4:0] a, input logic [7:0] exp);
        rq.push_back(exp);
        host.spi(1'b0, ch, a, 8'h00);
    endtask

    task automatic rd_i2c(input logic [6:0] a, input logic [7:0] exp);
        rq.push_back(exp);
        host.i2c(1'b0, 2'h1, a, 8'h00);
    endtask

    task automatic cfg(input logic [1:0] ch, input logic [7:0] v);
        host.spi(1'b1, ch, 5'h10, v);
    endtask

    task automatic trig(input logic [3:0] n);
        host.spi(1'b1, 2'h3, 5'h1F, {4'hE, n});
    endtask

    task automatic wait_off(input logic [3:0] exp);
        for (int i = 0; i < 12 && transmitter_off_o !== exp; i++)
            wt(1);
        chk({12'h000, transmitter_off_o}, {12'h000, exp});
        if (transmitter_off_o !== exp)
            end_of_test();
    endtask

    // Lines in mask fall together; starts expected on exp
    task automatic fall(input logic [3:0] mask, input logic [3:0] exp);
        sq.push_back(exp);
        tx_line_i = ~mask;
        wt(2);
        tx_line_i = 4'hF;
        wt(1);
    endtask

    task automatic tick;
        seed = lfsr(seed);
        baud_tick_i = seed[3:0] | 4'h1;
        wt(1);
        baud_tick_i = 4'h0;
        wt(1);
    endtask

    always @(negedge clk_i)
    begin
        if (acc_rvalid_o === 1'b1)
        begin
            er = (rq.size() > 0) ? rq.pop_front() : ~acc_rdata_o;
            chk({8'h00, acc_rdata_o}, {8'h00, er});
        end
        if (tx_start_o !== 4'h0)
        begin
            es = (sq.size() > 0) ? sq.pop_front() : 4'h0;
            chk({12'h000, tx_start_o}, {12'h000, es});
        end
    end

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial
    begin
        #100000;
        error_cnt++;
        end_of_test();
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        baud_tick_i = 4'h0;
        txq_has_data_i = 4'hF;
        tx_done_i = 4'h0;
        tx_line_i = 4'hF;
        mode_one_register_tx_off_i = 4'h0;
        seed = 8'h4A;
        wt(20);
        rst_i = 1'b0;
        chk({15'h0, ext_mode_o}, 16'h0000);
        host.ext(1'b1);
        wt(1);
        chk({15'h0, ext_mode_o}, 16'h0001);
        for (int c = 0; c < 4; c++)
        begin
            rd(c[1:0], 5'h10, 8'h00);
            rd(c[1:0], 5'h12, 8'h00);
            rd(c[1:0], 5'h05, REV);
            rd(c[1:0], 5'h0F, 8'h00);
        end
        host.spi(1'b1, 2'h0, 5'h05, 8'h00);
        rd(2'h0, 5'h05, REV);
        for (int c = 0; c < 4; c++)
            for (int a = 1; a < 5; a++)
            begin
                seed = lfsr(seed);
                vals[c][a] = seed;
                host.spi(1'b1, c[1:0], a[4:0], seed);
            end
        for (int c = 0; c < 4; c++)
            for (int a = 1; a < 5; a++)
                rd(c[1:0], a[4:0], vals[c][a]);
        $display("done: extended map");
        for (int c = 0; c < 4; c++)
        begin
            cfg(c[1:0], 8'h80);
            wt(2);
            chk(sysclk_gpio_en_o, 16'h0001 << (4 * c));
            cfg(c[1:0], 8'h00);
        end
        wt(2);
        chk(sysclk_gpio_en_o, 16'h0000);
        $display("done: clock route");
        host.ext(1'b0);
        wt(1);
        chk({15'h0, ext_mode_o}, 16'h0000);
        rd(2'h0, 5'h05, 8'h00);
        host.ext(1'b1);
        for (int i = 0; i < 8; i++)
        begin
            host.spi(1'b1, 2'h0, 5'h1F, codes[i]);
            wt(1);
            chk({15'h0, ext_mode_o}, 16'h0001);
        end
        $display("done: addressing modes");
        for (int n = 0; n < 16; n++)
        begin
            n4 = n[3:0];
            cfg(2'h0, {4'h1, n4});
            cfg(2'h1, {4'h1, n4});
            cfg(2'h2, {4'h1, n4 + 4'h1});
            cfg(2'h3, {4'h0, n4});
            wait_off(4'h7);
            trig(n4);
            wait_off(4'h4);
            fall(4'h7, 4'h3);
            for (int c = 0; c < 3; c++)
                cfg(c[1:0], 8'h00);
        end
        $display("done: triggers");
        txq_has_data_i = 4'h0;
        cfg(2'h0, 8'h15);
        wait_off(4'h1);
        trig(4'h5);
        wt(4);
        chk({12'h0, transmitter_off_o}, 16'h0001);
        txq_has_data_i = 4'hF;
        wt(4);
        chk({12'h0, transmitter_off_o}, 16'h0001);
        trig(4'h5);
        wait_off(4'h0);
        cfg(2'h0, 8'h55);
        tx_done_i = 4'h1;
        wait_off(4'h1);
        tx_done_i = 4'h0;
        trig(4'h5);
        wait_off(4'h0);
        cfg(2'h0, 8'h00);
        $display("done: auto disable");
        host.spi(1'b1, 2'h0, 5'h01, 8'h02);
        host.spi(1'b1, 2'h0, 5'h02, 8'h01);
        cfg(2'h0, 8'h35);
        wait_off(4'h1);
        trig(4'h5);
        wt(4);
        repeat (257) tick();
        wt(3);
        chk({12'h0, transmitter_off_o}, 16'h0001);
        tick();
        wait_off(4'h0);
        seed = lfsr(seed);
        mode_one_register_tx_off_i = seed[3:0];
        wt(1);
        chk({12'h0, transmitter_off_o}, {12'h0, seed[3:0]});
        mode_one_register_tx_off_i = 4'h0;
        cfg(2'h0, 8'h00);
        $display("done: delayed start");
        host.set_mode(1'b1);
        wt(6);
        for (int a = 1; a < 5; a++)
            rd_i2c(7'h20 + a[6:0], vals[1][a]);
        rd_i2c(7'h25, REV);
        host.i2c(1'b1, 2'h2, 7'h20, 8'h1A);
        wait_off(4'h4);
        host.i2c(1'b1, 2'h0, 7'h1F, 8'hEA);
        wait_off(4'h0);
        host.set_mode(1'b0);
        wt(6);
        $display("done: host port");
        rst_i = 1'b1;
        wt(2);
        rst_i = 1'b0;
        chk({15'h0, ext_mode_o}, 16'h0000);
        host.ext(1'b1);
        rd(2'h2, 5'h10, 8'h00);
        wt(4);
        $display("done: second reset");
        end_of_test();
    end
endmodule // gcts_top_test
